// File: inc/ssu_map.svh
// Register map, field positions, codes and timing constants of the serial unit.
`ifndef SSU_MAP_SVH
`define SSU_MAP_SVH
`define SSU_OFS_CTRL 8'h00
`define SSU_OFS_STAT 8'h04
`define SSU_OFS_DATA 8'h08
`define SSU_CTRL_MODE_LSB 0
`define SSU_CTRL_START_BIT 2
`define SSU_CTRL_EDGE_BIT 3
`define SSU_CTRL_ORDER_BIT 4
`define SSU_CTRL_CKS_LSB 5
`define SSU_CTRL_RESET 8'h00
`define SSU_STAT_RESET 6'h00
`define SSU_MODE_OFF 2'h0
`define SSU_MODE_DUPLEX 2'h3
`define SSU_CKS_EXT 3'h7
`define SSU_BITS_PER_BYTE 4'h8
`define SSU_CLK_NS 40
`define SSU_LINK_NS 320
`endif

// File: inc/ssu_pkg.sv
// Types shared by the synchronous serial unit.
package ssu_pkg;
  typedef struct packed {
    logic [2:0] clockSource;
    logic bitOrder;
    logic edgeSel;
    logic startStop;
    logic [1:0] transferMode;
  } ssu_ctrl_t;
  typedef struct packed {
    logic underrun;
    logic overrun;
    logic rxDone;
    logic txFull;
    logic shiftActive;
    logic operating;
  } ssu_stat_t;
  typedef struct packed {
    logic sclkOut;
    logic sclkOe;
    logic serialOut;
  } ssu_pins_t;
endpackage

// File: rtl/ssu_core.sv
// Full-duplex 8-bit synchronous serial unit with an APB register slave.
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns
`include "ssu_map.svh"

// Overview of operation
// - Mode field 11 selects full-duplex operation.
// - Clock source 111 selects external clock.
// - While operating only mode 00 or stop.
// - Start loads buffer, shifts out and in.
// - Internal clock drives clock pin at rate.
// - Start without load sends undefined data.
// - Start sets operating, shifting, raises interrupt.
// - Eighth received bit clears shift-active flag.
// - Write with empty shifter loads immediately.
// - Write with busy shifter sets full.
// - Each byte sets receive-done and interrupts.
// - Internal, full buffer: continue, maybe overrun.
// - Internal, empty buffer: halt until write.
// - External without write: resend, flag underrun.
// - External: byte while receive-done sets overrun.
// - Stop when idle is immediate, no interrupt.
// - Stop while shifting finishes byte, interrupts.
// - Stopped clears operating, shifting, full flags.
// - Output high after internal stop, internal halt or mode 00 only.
// - Mode 00 forces stop, clears all status flags.
// - Reading data buffer clears receive-done.
// - Reading status clears overrun flag.
// - Reading status clears underrun flag.
module ssu_core (
  input wire logic clk, // System clock.
  input wire logic srst, // Synchronous reset.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction.
  input wire logic [7:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error.
  input wire logic sclkIn, // Clock pin level.
  output ssu_pkg::ssu_pins_t pins, // Clock pin drive and serial out.
  input wire logic serialIn, // Serial input pin.
  output logic serialIrq // Interrupt request pulse.
);
  import ssu_pkg::*;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Codes 0 and 1 give half periods no longer than the input synchroniser's delay,
  // so a partner that launches on the clock edge is only met from code 2 upward.
  function automatic logic [7:0] halfPeriod(input logic [2:0] cks);
    halfPeriod = 8'h01 << cks;
  endfunction

  function automatic logic firstBit(input logic [7:0] v, input logic msb);
    firstBit = msb ? v[7] : v[0];
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  ssu_ctrl_t ctrl_reg, ctrl_next;
  ssu_stat_t stat_reg, stat_next;
  logic [7:0] txBuf_reg, txBuf_next;
  logic [7:0] rxBuf_reg, rxBuf_next;
  logic [7:0] txSh_reg, txSh_next;
  logic [7:0] rxSh_reg, rxSh_next;
  logic [7:0] capture;
  logic [3:0] bitCnt_reg, bitCnt_next;
  logic [7:0] div_reg, div_next;
  logic stopPend_reg, stopPend_next;
  logic sclk_reg, sclk_next;
  logic so_reg, so_next;
  logic irq_reg, irq_next;
  logic [31:0] rd_reg, rd_next;
  logic sync1_reg, sync2_reg, prev_reg;
  logic si1_reg, si2_reg;

  logic extSel, intRun, tick, fallEvt, riseEvt;
  logic sampleEvt, shiftEvt, active, byteDone;
  logic access, wrCtrl, wrData, rdStat, rdData, hit;
  ssu_ctrl_t wc;

  assign wc = ssu_ctrl_t'(pwdata[7:0]);
  assign extSel = ctrl_reg.clockSource == `SSU_CKS_EXT;
  assign intRun = stat_reg.operating & stat_reg.shiftActive & ~extSel;
  assign tick = intRun & (div_reg == halfPeriod(ctrl_reg.clockSource) - 8'h01);
  assign fallEvt = extSel ? (prev_reg & ~sync2_reg & stat_reg.operating)
                          : (tick & sclk_reg);
  assign riseEvt = extSel ? (~prev_reg & sync2_reg & stat_reg.operating)
                          : (tick & ~sclk_reg);
  assign sampleEvt = ctrl_reg.edgeSel ? fallEvt : riseEvt;
  assign shiftEvt = ctrl_reg.edgeSel ? riseEvt : fallEvt;
  assign active = stat_reg.shiftActive | (extSel & stat_reg.operating);
  assign byteDone = sampleEvt & active & (bitCnt_reg == `SSU_BITS_PER_BYTE - 4'h1);
  assign capture = ctrl_reg.bitOrder ? {rxSh_reg[6:0], si2_reg}
                                     : {si2_reg, rxSh_reg[7:1]};

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  assign hit = paddr == `SSU_OFS_CTRL || paddr == `SSU_OFS_STAT || paddr == `SSU_OFS_DATA;
  assign access = psel & penable;
  assign pready = access;
  assign pslverr = access & ~hit;
  assign prdata = rd_reg;
  assign wrCtrl = access & pwrite & (paddr == `SSU_OFS_CTRL);
  assign wrData = access & pwrite & (paddr == `SSU_OFS_DATA);
  assign rdStat = access & ~pwrite & (paddr == `SSU_OFS_STAT);
  assign rdData = access & ~pwrite & (paddr == `SSU_OFS_DATA);

  always_comb begin
    rd_next = rd_reg;
    if (psel & ~penable & ~pwrite) begin
      case (paddr)
        `SSU_OFS_CTRL: rd_next = {24'h000000, ctrl_reg};
        `SSU_OFS_STAT: rd_next = {26'h0000000, stat_reg};
        `SSU_OFS_DATA: rd_next = {24'h000000, rxBuf_reg};
        default: rd_next = 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------
  // Serial engine and register effects
  // ----------------------------------------
  always_comb begin
    ctrl_next = ctrl_reg;
    stat_next = stat_reg;
    txBuf_next = txBuf_reg;
    rxBuf_next = rxBuf_reg;
    txSh_next = txSh_reg;
    rxSh_next = rxSh_reg;
    bitCnt_next = bitCnt_reg;
    stopPend_next = stopPend_reg;
    sclk_next = sclk_reg;
    so_next = so_reg;
    irq_next = 1'b0;
    div_next = intRun ? (tick ? 8'h00 : div_reg + 8'h01) : 8'h00;
    if (tick) begin
      sclk_next = ~sclk_reg;
    end
    if (rdStat) begin
      stat_next.overrun = 1'b0;
      stat_next.underrun = 1'b0;
    end
    if (rdData) begin
      stat_next.rxDone = 1'b0;
    end
    if ((sampleEvt | shiftEvt) & extSel & stat_reg.operating & ~stat_reg.shiftActive) begin
      stat_next.underrun = 1'b1;
      stat_next.shiftActive = 1'b1;
    end
    if (shiftEvt & active & (bitCnt_reg != 4'h0)) begin
      txSh_next = ctrl_reg.bitOrder ? {txSh_reg[6:0], 1'b0} : {1'b0, txSh_reg[7:1]};
      so_next = ctrl_reg.bitOrder ? txSh_reg[6] : txSh_reg[1];
    end
    if (sampleEvt & active) begin
      rxSh_next = capture;
      bitCnt_next = bitCnt_reg + 4'h1;
    end
    if (byteDone) begin
      bitCnt_next = 4'h0;
      stat_next.shiftActive = 1'b0;
      stat_next.rxDone = 1'b1;
      irq_next = 1'b1;
      if (stat_reg.rxDone & ~rdData) begin
        stat_next.overrun = 1'b1;
      end else begin
        rxBuf_next = capture;
      end
      if (stopPend_reg) begin
        stopPend_next = 1'b0;
        stat_next.operating = 1'b0;
        stat_next.txFull = 1'b0;
        if (!extSel) begin
          so_next = 1'b1;
          sclk_next = 1'b1;
        end
      end else if (stat_reg.txFull) begin
        stat_next.txFull = 1'b0;
        stat_next.shiftActive = 1'b1;
        txSh_next = txBuf_reg;
        so_next = firstBit(txBuf_reg, ctrl_reg.bitOrder);
      end else if (!extSel) begin
        so_next = 1'b1;
        sclk_next = 1'b1;
      end else begin
        txSh_next = txBuf_reg;
        so_next = firstBit(txBuf_reg, ctrl_reg.bitOrder);
      end
    end
    if (wrData) begin
      txBuf_next = pwdata[7:0];
      if (stat_next.operating & ~stat_next.shiftActive & ~stopPend_next) begin
        stat_next.shiftActive = 1'b1;
        txSh_next = pwdata[7:0];
        so_next = firstBit(pwdata[7:0], ctrl_reg.bitOrder);
        bitCnt_next = 4'h0;
        irq_next = ~extSel;
      end else if (stat_next.operating) begin
        stat_next.txFull = 1'b1;
      end
    end
    if (wrCtrl) begin
      if (!stat_reg.operating) begin
        ctrl_next = wc;
        if (wc.transferMode == `SSU_MODE_OFF) begin
          so_next = 1'b1;
          ctrl_next.startStop = 1'b0;
        end else if (wc.startStop && wc.transferMode == `SSU_MODE_DUPLEX) begin
          stat_next.operating = 1'b1;
          stat_next.shiftActive = 1'b1;
          irq_next = 1'b1;
          txSh_next = txBuf_reg;
          so_next = firstBit(txBuf_reg, wc.bitOrder);
          bitCnt_next = 4'h0;
          sclk_next = 1'b1;
          stopPend_next = 1'b0;
        end else begin
          ctrl_next.startStop = 1'b0;
        end
      end else if (wc.transferMode == `SSU_MODE_OFF) begin
        ctrl_next.transferMode = `SSU_MODE_OFF;
        ctrl_next.startStop = 1'b0;
        stat_next = `SSU_STAT_RESET;
        stopPend_next = 1'b0;
        so_next = 1'b1;
        sclk_next = 1'b1;
        bitCnt_next = 4'h0;
        irq_next = 1'b0;
      end else if (!wc.startStop) begin
        ctrl_next.startStop = 1'b0;
        if (!stat_next.shiftActive) begin
          stat_next.operating = 1'b0;
          stat_next.txFull = 1'b0;
          stopPend_next = 1'b0;
          if (!extSel) begin
            so_next = 1'b1;
            sclk_next = 1'b1;
          end
        end else begin
          stopPend_next = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_reg <= `SSU_CTRL_RESET;
      stat_reg <= `SSU_STAT_RESET;
      txBuf_reg <= 8'h00;
      rxBuf_reg <= 8'h00;
      txSh_reg <= 8'h00;
      rxSh_reg <= 8'h00;
      bitCnt_reg <= 4'h0;
      div_reg <= 8'h00;
      stopPend_reg <= 1'b0;
      sclk_reg <= 1'b1;
      so_reg <= 1'b1;
      irq_reg <= 1'b0;
      rd_reg <= 32'h00000000;
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      prev_reg <= 1'b1;
    end else begin
      ctrl_reg <= ctrl_next;
      stat_reg <= stat_next;
      txBuf_reg <= txBuf_next;
      rxBuf_reg <= rxBuf_next;
      txSh_reg <= txSh_next;
      rxSh_reg <= rxSh_next;
      bitCnt_reg <= bitCnt_next;
      div_reg <= div_next;
      stopPend_reg <= stopPend_next;
      sclk_reg <= sclk_next;
      so_reg <= so_next;
      irq_reg <= irq_next;
      rd_reg <= rd_next;
      sync1_reg <= sclkIn;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  // The serial input pin passes two flip-flops before the shift register takes it.
  always_ff @(posedge clk) begin
    si1_reg <= serialIn;
    si2_reg <= si1_reg;
  end

  assign pins.sclkOut = sclk_reg;
  assign pins.sclkOe = ~extSel & (ctrl_reg.transferMode != `SSU_MODE_OFF);
  assign pins.serialOut = so_reg;
  assign serialIrq = irq_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence sStartWrite;
    wrCtrl && !stat_reg.operating && wc.startStop;
  endsequence

  sequence sDone;
    byteDone && !stopPend_reg && !wrCtrl && !wrData;
  endsequence

  AST_MODE_GATE: assert property (
    sStartWrite and (wc.transferMode != `SSU_MODE_DUPLEX) |=> !stat_reg.operating)
    else $error("Start accepted outside full-duplex mode.");

  AST_START_FLAGS: assert property (
    sStartWrite and (wc.transferMode == `SSU_MODE_DUPLEX)
      |=> stat_reg.operating && stat_reg.shiftActive && serialIrq)
    else $error("Start did not set flags and interrupt.");

  AST_LOCKED: assert property (
    wrCtrl && stat_reg.operating |=> $stable(ctrl_reg.clockSource)
      && $stable(ctrl_reg.edgeSel) && $stable(ctrl_reg.bitOrder))
    else $error("Locked control field changed while operating.");

  AST_DONE_FLAGS: assert property (
    sDone |=> stat_reg.rxDone && serialIrq)
    else $error("Byte end without receive-done and interrupt.");

  AST_HALT: assert property (
    sDone and (!extSel && !stat_reg.txFull)
      |=> !stat_reg.shiftActive && pins.serialOut ##1 pins.sclkOut)
    else $error("Internal clock did not halt idle.");

  AST_CONTINUE: assert property (
    sDone and stat_reg.txFull |=> stat_reg.shiftActive && !stat_reg.txFull)
    else $error("Buffered byte not taken at byte end.");

  AST_OVERRUN: assert property (
    sDone and (stat_reg.rxDone && !rdData) |=> stat_reg.overrun)
    else $error("Overrun not flagged.");

  AST_FORCE: assert property (
    wrCtrl && stat_reg.operating && wc.transferMode == `SSU_MODE_OFF
      |=> stat_reg == `SSU_STAT_RESET && pins.serialOut && !ctrl_reg.startStop)
    else $error("Forced stop incomplete.");

  AST_QUIET_STOP: assert property (
    wrCtrl && stat_reg.operating && !stat_reg.shiftActive && !sampleEvt && !shiftEvt
      && wc.transferMode != `SSU_MODE_OFF && !wc.startStop
      |=> !stat_reg.operating && !serialIrq)
    else $error("Idle stop not immediate or interrupted.");

  AST_CLK_RUN: assert property (
    intRun && !wrCtrl |-> ##[1:130] ($changed(pins.sclkOut) || !intRun))
    else $error("Internal serial clock stalled.");
endmodule

// File: testbench/ssu_core_tb_top.sv
// Self-checking bench for the synchronous serial unit.
`timescale 1ns/1ns
`include "ssu_map.svh"
module ssu_core_tb_top;
  import ssu_pkg::*;
  typedef struct {
    logic [2:0] cks;
    logic order;
    logic [7:0] tx;
    logic [7:0] rx;
  } ssu_row_t;
  logic clk, srst, psel, penable, pwrite, pready, pslverr, serialIn, serialIrq, err;
  logic extSclk, sclkLine, pActive, pMsb;
  logic [7:0] paddr, pTx, pRx;
  logic [31:0] pwdata, prdata, rd;
  ssu_pins_t pins;
  int failures = 0, total_checks = 0, cycles = 0, irqCount = 0;
  ssu_row_t rows[4] = '{'{3'h2, 1'h0, 8'hA5, 8'h3C}, '{3'h3, 1'h1, 8'hC3, 8'h5A},
                        '{3'h6, 1'h0, 8'h81, 8'h7E}, '{3'h7, 1'h1, 8'hE1, 8'h18}};
  assign sclkLine = pins.sclkOe ? pins.sclkOut : extSclk;
  ssu_core u_dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sclkIn(sclkLine), .pins(pins), .serialIn(serialIn), .serialIrq(serialIrq));
  ssu_partner u_partner (.clk(clk), .sclk(sclkLine), .serialOut(pins.serialOut),
    .active(pActive), .msbFirst(pMsb), .txByte(pTx), .serialIn(serialIn),
    .extSclk(extSclk), .rxByte(pRx));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (serialIrq === 1'h1) irqCount++;
    if (cycles == 40000) begin
      failures++;
      stop_test;
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pActive, pMsb, pTx} = '0;
    srst = 1'h1;
    repeat (20) @(posedge clk);
    srst <= 1'h0;
    apb(1'h0, `SSU_OFS_CTRL, 32'h0);
    check(rd, 32'h0);
    apb(1'h0, `SSU_OFS_STAT, 32'h0);
    check(rd, 32'h0);
    check({31'h0, pins.serialOut}, 32'h1);
    apb(1'h0, 8'h0C, 32'h0);
    check({31'h0, err}, 32'h1);
    $display("Reset test done");
    foreach (rows[i]) begin
      pMsb <= rows[i].order;
      pTx <= rows[i].rx;
      pActive <= 1'h1;
      irqCount = 0;
      apb(1'h1, `SSU_OFS_DATA, {24'h0, rows[i].tx});
      apb(1'h1, `SSU_OFS_CTRL, {24'h0, rows[i].cks, rows[i].order, 4'h7});
      if (rows[i].cks == 3'h7) u_partner.run_clock(8);
      do apb(1'h0, `SSU_OFS_STAT, 32'h0); while (rd[3] !== 1'h1);
      check(rd, 32'h09);
      check({31'h0, pins.sclkOe}, {31'h0, rows[i].cks != 3'h7});
      check({31'h0, pins.sclkOut}, 32'h1);
      apb(1'h1, `SSU_OFS_CTRL, {24'h0, rows[i].cks, rows[i].order, 4'h3});
      pActive <= 1'h0;
      apb(1'h0, `SSU_OFS_STAT, 32'h0);
      check(rd, 32'h08);
      apb(1'h0, `SSU_OFS_DATA, 32'h0);
      check(rd, {24'h0, rows[i].rx});
      apb(1'h0, `SSU_OFS_STAT, 32'h0);
      check(rd, 32'h0);
      check({24'h0, pRx}, {24'h0, rows[i].tx});
      check(irqCount, 2);
      if (rows[i].cks != 3'h7) check({31'h0, pins.serialOut}, 32'h1);
      apb(1'h1, `SSU_OFS_CTRL, 32'h0);
      @(posedge clk);
      check({31'h0, pins.serialOut}, 32'h1);
      $display("Row %0d done", i);
    end
    pMsb <= 1'h0;
    pTx <= 8'h96;
    pActive <= 1'h1;
    apb(1'h1, `SSU_OFS_DATA, 32'h5A);
    apb(1'h1, `SSU_OFS_CTRL, 32'hE7);
    apb(1'h0, `SSU_OFS_STAT, 32'h0);
    check(rd, 32'h03);
    apb(1'h1, `SSU_OFS_CTRL, 32'h1F);
    apb(1'h0, `SSU_OFS_CTRL, 32'h0);
    check(rd, 32'hE7);
    apb(1'h1, `SSU_OFS_DATA, 32'h33);
    apb(1'h0, `SSU_OFS_STAT, 32'h0);
    check(rd, 32'h07);
    u_partner.run_clock(8);
    check({24'h0, pRx}, 32'h5A);
    apb(1'h0, `SSU_OFS_STAT, 32'h0);
    check(rd & 32'h3D, 32'h09);
    u_partner.run_clock(8);
    check({24'h0, pRx}, 32'h33);
    apb(1'h0, `SSU_OFS_STAT, 32'h0);
    check(rd & 32'h10, 32'h10);
    u_partner.run_clock(8);
    check({24'h0, pRx}, 32'h33);
    apb(1'h0, `SSU_OFS_STAT, 32'h0);
    check(rd & 32'h30, 32'h30);
    apb(1'h0, `SSU_OFS_STAT, 32'h0);
    check(rd & 32'h30, 32'h0);
    apb(1'h0, `SSU_OFS_DATA, 32'h0);
    check(rd, 32'h96);
    apb(1'h1, `SSU_OFS_CTRL, 32'h0);
    apb(1'h0, `SSU_OFS_STAT, 32'h0);
    check(rd, 32'h0);
    check({31'h0, pins.serialOut}, 32'h1);
    $display("External stream test done");
    pTx <= 8'h69;
    apb(1'h1, `SSU_OFS_DATA, 32'hC6);
    apb(1'h1, `SSU_OFS_CTRL, 32'hE7);
    u_partner.run_clock(4);
    apb(1'h1, `SSU_OFS_CTRL, 32'hE3);
    apb(1'h0, `SSU_OFS_STAT, 32'h0);
    check(rd & 32'h1, 32'h1);
    irqCount = 0;
    u_partner.run_clock(4);
    repeat (5) @(posedge clk);
    apb(1'h0, `SSU_OFS_STAT, 32'h0);
    check(rd & 32'h0F, 32'h08);
    check(irqCount, 1);
    check({24'h0, pRx}, 32'hC6);
    pActive <= 1'h0;
    $display("Reserved stop test done");
    apb(1'h1, `SSU_OFS_CTRL, 32'h67);
    srst <= 1'h1;
    repeat (2) @(posedge clk);
    srst <= 1'h0;
    apb(1'h0, `SSU_OFS_STAT, 32'h0);
    check(rd, 32'h0);
    check({31'h0, pins.serialOut}, 32'h1);
    $display("Mid-run reset test done");
    stop_test;
  end
endmodule

// File: testbench/ssu_partner.sv
// Behavioural model of the external serial partner on the link pins.
`timescale 1ns/1ns
module ssu_partner (
  input wire logic clk, // System clock, paces the released data line.
  input wire logic sclk, // Level on the serial clock line.
  input wire logic serialOut, // Data from the device.
  input wire logic active, // Partner selected.
  input wire logic msbFirst, // Bit order of both directions.
  input wire logic [7:0] txByte, // Byte the partner sends.
  output logic serialIn, // Data to the device.
  output logic extSclk, // Clock the partner drives, idle high.
  output logic [7:0] rxByte // Last whole byte taken in.
);
  logic [2:0] bitCnt = 3'h0;
  logic [7:0] shiftIn = 8'h00;
  logic txBit = 1'h1;
  initial begin
    extSclk = 1'h1;
    rxByte = 8'h00;
  end
  // A released data line toggles, so a stale bit is never taken for data.
  // A launched bit reaches the pin at the next system clock edge.
  always @(posedge clk) begin
    serialIn <= active ? txBit : !(serialIn === 1'h1);
  end
  // Edges count only while selected, so the line's power-up step cannot skew frames.
  always @(negedge sclk) begin
    if (active) begin
      txBit <= txByte[msbFirst ? 3'h7 - bitCnt : bitCnt];
    end
  end
  always @(posedge sclk) begin
    if (active) begin
      shiftIn = msbFirst ? {shiftIn[6:0], serialOut} : {serialOut, shiftIn[7:1]};
      if (bitCnt == 3'h7) begin
        rxByte <= shiftIn;
      end
      bitCnt <= bitCnt + 3'h1;
    end
  end
  // The clock only runs inside frames, with every edge 7 ns after a rising edge of clk.
  task automatic run_clock(input int bits);
    #7;
    repeat (bits) begin
      extSclk = 1'h0;
      #160;
      extSclk = 1'h1;
      #160;
    end
  endtask
endmodule
